// File: verilog/ipmf_pkg.sv
// Constants for the input power metering and fault flag block.
package ipmf_pkg;

  // Command codes on the serial management bus.
  localparam logic [15:0] CMD_VIN_READ   = 16'h0088;
  localparam logic [15:0] CMD_IIN_READ   = 16'h0089;
  localparam logic [15:0] CMD_VOUT_READ  = 16'h008B;
  localparam logic [15:0] CMD_PIN_READ   = 16'h0097;
  localparam logic [15:0] CMD_AVG_WINDOW = 16'hFE3A;
  localparam logic [15:0] CMD_LINE_SRC   = 16'hFE3C;
  localparam logic [15:0] CMD_LAT_CTRL   = 16'hFE80;
  localparam logic [15:0] CMD_LAT_SYS    = 16'hFE81;
  localparam logic [15:0] CMD_LAT_SUP    = 16'hFE82;

  // Widths.
  localparam int CODE_W    = 16;
  localparam int DATA_W    = 16;
  localparam int MANT_W    = 11;
  localparam int EXP_W     = 5;
  localparam int HC_W      = 11;
  localparam int SAMPLE_W  = 12;
  localparam int LEVEL_W   = 16;
  localparam int ACC_W     = 32;
  localparam int AVG_W     = 24;
  localparam int HCNT_W    = 14;
  localparam int FLAG_W    = 8;
  localparam int LAT_COUNT = 3;

  // Linear format exponent ranges.
  localparam int VIN_EXP_MIN  = -3;
  localparam int VIN_EXP_MAX  = -1;
  localparam int IIN_EXP_MIN  = -10;
  localparam int IIN_EXP_MAX  = -5;
  localparam int PIN_EXP_MIN  = -4;
  localparam int PIN_EXP_MAX  = 3;
  localparam int VOUT_EXP_MIN = -3;
  localparam int VOUT_EXP_MAX = 0;
  localparam logic [MANT_W-1:0] MANT_LIMIT = 11'h400;
  localparam logic [MANT_W-1:0] MANT_SAT   = 11'h3FF;

  // Half cycle integration scale and averaging window.
  localparam int                 HC_SHIFT      = 13;
  localparam logic [HC_W-1:0]    HC_SAT        = 11'h7FF;
  localparam logic [FLAG_W-1:0]  AVG_WIN_RESET = 8'h01;
  localparam logic [3:0]         AVG_WIN_MAX   = 4'hD;
  localparam logic [FLAG_W-1:0]  LINE_SRC_RESET = 8'h03;
  localparam int LSRC_BROWNOUT = 0;
  localparam int LSRC_RELAY    = 1;
  localparam int LSRC_VIN_LOW  = 2;

  // Open loop detection threshold in sense converter codes.
  localparam int OPEN_LOOP_MV      = 100;
  localparam int SENSE_UV_PER_CODE = 400;
  localparam logic [SAMPLE_W-1:0] OPEN_LOOP_CODES =
    SAMPLE_W'((OPEN_LOOP_MV * 1000) / SENSE_UV_PER_CODE);

  // Index of each latched flag register.
  localparam int LAT_CTRL = 0;
  localparam int LAT_SYS  = 1;
  localparam int LAT_SUP  = 2;

endpackage

// File: verilog/ipmf_metering_flags.sv
// Input power metering, readback formatting and latched fault flags.
`timescale 1ns/1ps
// Summary of operation
// - Integrate samples each half line cycle into hidden 11-bit values.
// - Software sets the averaging window from half a line cycle to 4096 line cycles.
// - Each window end publishes a new average power, held until the next.
// - Vin, Iin, Vout and power are reported in linear format registers.
// - Exponents: Vin -3..-1, Iin -10..-5, power -4..+3.
// - Mantissas are 11 bits; Vout exponent stays within -3..0.
// - Fault flags read 1 while the fault is present.
// - Output-bad and line-good flags are active low goodness flags.
// - Flag pins are active high; output good pin is inverse of output-bad.
// - Three flag registers latch set flags and clear on read.
// - Bit 7 flags maximum modulation, bit 6 minimum modulation.
// - Open loop flag when feedback and overvoltage sense differ over ~100 mV.
// - Quick overvoltage flag follows the overvoltage sense comparator.
// - Period detect failure sets its flag while maximum period is used.
// - Brownout flag while line level below turn-on; may feed line-good.
// - Ramp-active flag set throughout soft start.
// - Relay-open flag drives relay pin and may feed line-good.
// - Second register flags memory unlocked, bad memory, marginal strap.
// - High-line flag and quick overcurrent flag from current limit pin.
// - Sync-locked flag; line-good flag is programmable and is the inverse of its pin.
// - Third register flags light load, fast loop, core and supply rails.
// - Manufacturer status bit reflects the three latched registers.
module ipmf_metering_flags (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire logic                           cmd_valid,
  input  wire logic                           cmd_write,
  input  wire logic [ipmf_pkg::CODE_W-1:0]    cmd_code,
  input  wire logic [ipmf_pkg::DATA_W-1:0]    cmd_wdata,
  input  wire logic                           sample_strobe,
  input  wire logic [ipmf_pkg::SAMPLE_W-1:0]  line_voltage_input,
  input  wire logic [ipmf_pkg::SAMPLE_W-1:0]  line_current_sample,
  input  wire logic                           half_cycle_end,
  input  wire logic [ipmf_pkg::HC_W-1:0]      vin_on_threshold,
  input  wire logic [ipmf_pkg::HC_W-1:0]      high_line_threshold,
  input  wire logic [ipmf_pkg::LEVEL_W-1:0]   vin_level,
  input  wire logic [ipmf_pkg::LEVEL_W-1:0]   iin_level,
  input  wire logic [ipmf_pkg::LEVEL_W-1:0]   vout_level,
  input  wire logic [ipmf_pkg::SAMPLE_W-1:0]  feedback_sense_pin,
  input  wire logic [ipmf_pkg::SAMPLE_W-1:0]  overvoltage_sense_pin,
  input  wire logic                           overvoltage_comparator,
  input  wire logic                           current_limit_pin,
  input  wire logic                           max_modulation,
  input  wire logic                           min_modulation,
  input  wire logic                           period_detect_fail,
  input  wire logic                           soft_start_active,
  input  wire logic                           relay_off,
  input  wire logic                           vin_low,
  input  wire logic                           output_bad,
  input  wire logic                           nvm_unlocked,
  input  wire logic                           nvm_crc_bad,
  input  wire logic                           address_strap_marginal,
  input  wire logic                           sync_locked,
  input  wire logic                           light_load,
  input  wire logic                           fast_loop_active,
  input  wire logic                           core_rail_over,
  input  wire logic                           supply_over,
  input  wire logic                           supply_under,
  output logic                                rsp_valid,
  output logic [ipmf_pkg::DATA_W-1:0]         rsp_data,
  output logic                                rsp_error,
  output logic                                output_good_pin,
  output logic                                line_good_pin,
  output logic                                relay_close_pin,
  output logic                                supply_shutdown,
  output logic                                mfr_status_bit
);
  import ipmf_pkg::*;

  // Linear format: least exponent whose mantissa fits, saturating at the top.
  function automatic logic [DATA_W-1:0] lin_fmt(input logic [AVG_W-1:0] raw,
                                                input int emin, input int emax);
    logic [DATA_W-1:0] r;
    logic              found;
    logic [AVG_W-1:0]  m;
    r     = {EXP_W'(emax), MANT_SAT};
    found = 1'b0;
    m     = '0;
    for (int e = emin; e <= emax; e++) begin
      m = raw >> (e - emin);
      if (!found && m < AVG_W'(MANT_LIMIT)) begin
        found = 1'b1;
        r     = {EXP_W'(e), m[MANT_W-1:0]};
      end
    end
    return r;
  endfunction

  logic [1:0]            cmp_meta;
  logic [1:0]            cmp_sync;
  logic [ACC_W-1:0]      pwr_acc;
  logic [ACC_W-1:0]      vin_acc;
  logic [HC_W-1:0]       hc_power;
  logic [HC_W-1:0]       hc_vin;
  logic                  hc_done;
  logic [AVG_W-1:0]      avg_acc;
  logic [HCNT_W-1:0]     half_cnt;
  logic [FLAG_W-1:0]     avg_window_cfg;
  logic [FLAG_W-1:0]     line_src_cfg;
  logic [DATA_W-1:0]     average_input_power_reading;
  logic [DATA_W-1:0]     input_voltage_reading;
  logic [DATA_W-1:0]     input_current_reading;
  logic [DATA_W-1:0]     output_voltage_reading;
  logic [FLAG_W-1:0]     live [LAT_COUNT];
  logic [FLAG_W-1:0]     lat  [LAT_COUNT];
  logic [LAT_COUNT-1:0]  clear_read;
  logic                  open_loop_flag;
  logic                  brownout_low_line_flag;
  logic                  high_line_flag;
  logic                  line_good_flag;
  logic                  output_bad_flag;
  logic [SAMPLE_W-1:0]   sense_diff;
  logic [3:0]            win_code;
  logic [HCNT_W-1:0]     win_halves;
  logic [AVG_W-1:0]      next_avg_sum;
  logic [HC_W-1:0]       next_hc_power;
  logic [HC_W-1:0]       next_hc_vin;
  logic                  cfg_write;

  // Comparator outputs are asynchronous to the controller clock.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
    end else begin
      cmp_meta <= {current_limit_pin, overvoltage_comparator};
      cmp_sync <= cmp_meta;
    end
  end

  // Half cycle integration. Results stay internal and are used for averaging
  // and line level checks only.
  always_comb begin
    next_hc_power = (|pwr_acc[ACC_W-1:HC_SHIFT+HC_W]) ? HC_SAT
                  : pwr_acc[HC_SHIFT +: HC_W];
    next_hc_vin   = (|vin_acc[ACC_W-1:HC_SHIFT+HC_W]) ? HC_SAT
                  : vin_acc[HC_SHIFT +: HC_W];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwr_acc  <= '0;
      vin_acc  <= '0;
      hc_power <= '0;
      hc_vin   <= '0;
      hc_done  <= 1'b0;
    end else begin
      hc_done <= half_cycle_end;
      if (half_cycle_end) begin
        hc_power <= next_hc_power;
        hc_vin   <= next_hc_vin;
        pwr_acc  <= '0;
        vin_acc  <= '0;
      end else if (sample_strobe) begin
        pwr_acc <= pwr_acc + ACC_W'(line_voltage_input) * ACC_W'(line_current_sample);
        vin_acc <= vin_acc + ACC_W'(line_voltage_input) * ACC_W'(line_voltage_input);
      end
    end
  end

  // Window code 0 publishes every half cycle; code k publishes the mean of
  // 2^k half cycles, that is 2^(k-1) line cycles, up to 4096 line cycles.
  always_comb begin
    win_code     = (avg_window_cfg[3:0] > AVG_WIN_MAX) ? AVG_WIN_MAX
                 : avg_window_cfg[3:0];
    win_halves   = HCNT_W'(1) << win_code;
    next_avg_sum = avg_acc + AVG_W'(hc_power);
  end

  assign cfg_write = cmd_valid && cmd_write;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avg_acc                     <= '0;
      half_cnt                    <= '0;
      average_input_power_reading <= '0;
    end else if (cfg_write && cmd_code == CMD_AVG_WINDOW) begin
      // A new window length restarts the running sum so no mixed mean leaks out.
      avg_acc  <= '0;
      half_cnt <= '0;
    end else if (hc_done) begin
      if (half_cnt + HCNT_W'(1) >= win_halves) begin
        // Whole word written in one edge, so a read never sees a mix.
        average_input_power_reading <= lin_fmt(next_avg_sum >> win_code,
                                               PIN_EXP_MIN, PIN_EXP_MAX);
        avg_acc  <= '0;
        half_cnt <= '0;
      end else begin
        avg_acc  <= next_avg_sum;
        half_cnt <= half_cnt + HCNT_W'(1);
      end
    end
  end

  // Instantaneous readings are refreshed every cycle from the measurement path.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      input_voltage_reading  <= '0;
      input_current_reading  <= '0;
      output_voltage_reading <= '0;
    end else begin
      input_voltage_reading  <= lin_fmt(AVG_W'(vin_level), VIN_EXP_MIN, VIN_EXP_MAX);
      input_current_reading  <= lin_fmt(AVG_W'(iin_level), IIN_EXP_MIN, IIN_EXP_MAX);
      output_voltage_reading <= lin_fmt(AVG_W'(vout_level), VOUT_EXP_MIN,
                                        VOUT_EXP_MAX);
    end
  end

  // Configuration registers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avg_window_cfg <= AVG_WIN_RESET;
      line_src_cfg   <= LINE_SRC_RESET;
    end else if (cfg_write) begin
      if (cmd_code == CMD_AVG_WINDOW) begin
        avg_window_cfg <= cmd_wdata[FLAG_W-1:0];
      end
      if (cmd_code == CMD_LINE_SRC) begin
        line_src_cfg <= cmd_wdata[FLAG_W-1:0];
      end
    end
  end

  // Live condition flags, each high while its bad condition holds.
  always_comb begin
    sense_diff = (feedback_sense_pin > overvoltage_sense_pin)
               ? feedback_sense_pin - overvoltage_sense_pin
               : overvoltage_sense_pin - feedback_sense_pin;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      open_loop_flag         <= 1'b0;
      brownout_low_line_flag <= 1'b0;
      high_line_flag         <= 1'b0;
      output_bad_flag        <= 1'b1;
      line_good_flag         <= 1'b1;
    end else begin
      open_loop_flag  <= sense_diff > OPEN_LOOP_CODES;
      output_bad_flag <= output_bad;
      if (hc_done) begin
        brownout_low_line_flag <= hc_vin < vin_on_threshold;
        high_line_flag         <= hc_vin > high_line_threshold;
      end
      // Line good reads 1 when the line is bad, from the enabled sources.
      line_good_flag <= (line_src_cfg[LSRC_BROWNOUT] && brownout_low_line_flag)
                     || (line_src_cfg[LSRC_RELAY] && relay_off)
                     || (line_src_cfg[LSRC_VIN_LOW] && vin_low);
    end
  end

  always_comb begin
    live[LAT_CTRL] = {max_modulation, min_modulation, open_loop_flag, cmp_sync[0],
                      period_detect_fail, brownout_low_line_flag, soft_start_active,
                      relay_off};
    live[LAT_SYS]  = {1'b0, nvm_unlocked, nvm_crc_bad, address_strap_marginal,
                      high_line_flag, cmp_sync[1], sync_locked,
                      line_good_flag};
    live[LAT_SUP]  = {2'b00, light_load, fast_loop_active, core_rail_over,
                      supply_over, supply_under, 1'b0};
    clear_read[LAT_CTRL] = cmd_valid && !cmd_write && cmd_code == CMD_LAT_CTRL;
    clear_read[LAT_SYS]  = cmd_valid && !cmd_write && cmd_code == CMD_LAT_SYS;
    clear_read[LAT_SUP]  = cmd_valid && !cmd_write && cmd_code == CMD_LAT_SUP;
  end

  // Latched copies: a read clears them, but a flag present during that read
  // is caught again, so a short fault is never lost.
  for (genvar g = 0; g < LAT_COUNT; g++) begin : g_latch
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        lat[g] <= '0;
      end else if (clear_read[g]) begin
        lat[g] <= live[g];
      end else begin
        lat[g] <= lat[g] | live[g];
      end
    end
  end

  // Pins and status outputs.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      output_good_pin <= 1'b0;
      line_good_pin   <= 1'b0;
      relay_close_pin <= 1'b0;
      supply_shutdown <= 1'b0;
      mfr_status_bit  <= 1'b0;
    end else begin
      output_good_pin <= !output_bad_flag;
      line_good_pin   <= !line_good_flag;
      relay_close_pin <= !relay_off;
      supply_shutdown <= supply_under;
      mfr_status_bit  <= |{lat[LAT_CTRL], lat[LAT_SYS], lat[LAT_SUP]};
    end
  end

  // Command answers, one cycle after the request.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_error <= 1'b0;
      rsp_data  <= '0;
      if (cmd_valid) begin
        case (cmd_code)
          CMD_VIN_READ:   rsp_data <= input_voltage_reading;
          CMD_IIN_READ:   rsp_data <= input_current_reading;
          CMD_VOUT_READ:  rsp_data <= output_voltage_reading;
          CMD_PIN_READ:   rsp_data <= average_input_power_reading;
          CMD_AVG_WINDOW: rsp_data <= {8'h00, avg_window_cfg};
          CMD_LINE_SRC:   rsp_data <= {8'h00, line_src_cfg};
          CMD_LAT_CTRL:   rsp_data <= {8'h00, lat[LAT_CTRL]};
          CMD_LAT_SYS:    rsp_data <= {8'h00, lat[LAT_SYS]};
          CMD_LAT_SUP:    rsp_data <= {8'h00, lat[LAT_SUP]};
          default:        rsp_error <= 1'b1;
        endcase
        // Writes to readback or flag registers are refused.
        if (cmd_write && cmd_code != CMD_AVG_WINDOW && cmd_code != CMD_LINE_SRC) begin
          rsp_error <= 1'b1;
        end
      end
    end
  end

  property p_clear_keeps_new;
    @(posedge clock) disable iff (!rst_n)
      clear_read[LAT_CTRL] && live[LAT_CTRL][7] |=> lat[LAT_CTRL][7];
  endproperty
  a_clear_keeps_new: assert property (p_clear_keeps_new) else $error("flag lost on read");

  property p_latch_holds;
    @(posedge clock) disable iff (!rst_n)
      lat[LAT_SUP][1] && !clear_read[LAT_SUP] |=> lat[LAT_SUP][1];
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched flag dropped");

  property p_read_returns_latch;
    @(posedge clock) disable iff (!rst_n)
      clear_read[LAT_SYS] |=> rsp_valid && rsp_data[7:0] == $past(lat[LAT_SYS]);
  endproperty
  a_read_returns_latch: assert property (p_read_returns_latch) else $error("bad flag read");

  property p_good_pin;
    @(posedge clock) disable iff (!rst_n)
      output_bad_flag |=> !output_good_pin;
  endproperty
  a_good_pin: assert property (p_good_pin) else $error("output good pin not inverted");

  property p_pin_exp;
    @(posedge clock) disable iff (!rst_n)
      $signed(average_input_power_reading[DATA_W-1:MANT_W]) >= PIN_EXP_MIN
      && $signed(average_input_power_reading[DATA_W-1:MANT_W]) <= PIN_EXP_MAX;
  endproperty
  a_pin_exp: assert property (p_pin_exp) else $error("power exponent out of range");

  property p_vout_exp;
    @(posedge clock) disable iff (!rst_n)
      ##1 $signed(output_voltage_reading[DATA_W-1:MANT_W]) >= VOUT_EXP_MIN
      && $signed(output_voltage_reading[DATA_W-1:MANT_W]) <= VOUT_EXP_MAX;
  endproperty
  a_vout_exp: assert property (p_vout_exp) else $error("vout exponent out of range");

  property p_power_stable;
    @(posedge clock) disable iff (!rst_n)
      !hc_done |=> $stable(average_input_power_reading);
  endproperty
  a_power_stable: assert property (p_power_stable) else $error("power changed mid window");

  property p_open_loop;
    @(posedge clock) disable iff (!rst_n)
      sense_diff > OPEN_LOOP_CODES |=> open_loop_flag ##1 lat[LAT_CTRL][5];
  endproperty
  a_open_loop: assert property (p_open_loop) else $error("open loop not flagged");

  property p_mfr_bit;
    @(posedge clock) disable iff (!rst_n)
      (|lat[LAT_SYS]) |=> mfr_status_bit;
  endproperty
  a_mfr_bit: assert property (p_mfr_bit) else $error("mfr status bit missing");

  property p_line_pin;
    @(posedge clock) disable iff (!rst_n)
      line_good_flag |=> !line_good_pin;
  endproperty
  a_line_pin: assert property (p_line_pin) else $error("line good pin wrong");

  c_publish: cover property (@(posedge clock) disable iff (!rst_n)
    hc_done && half_cnt + HCNT_W'(1) >= win_halves);
  c_clear_set: cover property (@(posedge clock) disable iff (!rst_n)
    clear_read[LAT_CTRL] && |live[LAT_CTRL]);
  c_unmapped: cover property (@(posedge clock) disable iff (!rst_n) rsp_error);

endmodule

// File: verif/ipmf_host_model.sv
// Host microcontroller that issues commands on the management port.
`timescale 1ns/1ps
module ipmf_host_model (
  input  wire logic        clock,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_error,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [15:0]      cmd_code,
  output logic [15:0]      cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 16'h0000;
    cmd_wdata = 16'h0000;
  end

  // Released code and data lines show the inverse so stale values never match.
  task automatic access(input logic wr, input logic [15:0] code, input logic [15:0] wd,
                        output logic [16:0] rsp);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= wd;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    cmd_wdata <= ~wd;
    @(posedge clock);
    rsp = (rsp_valid === 1'b1) ? {rsp_error, rsp_data} : 17'h1FFFF;
  endtask
endmodule

// File: verif/input_power_metering_and_flags_test.sv
// Self-checking bench for the metering and latched flag block.
`timescale 1ns/1ps
module input_power_metering_and_flags_test;
  import ipmf_pkg::*;
  logic        clock, rst_n, sample_strobe, half_cycle_end;
  logic        cmd_valid, cmd_write, rsp_valid, rsp_error, og, rc, sd, mfr, lg;
  logic [15:0] cmd_code, cmd_wdata, rsp_data;
  logic [11:0] v_smp, i_smp, fb, ov;
  logic [10:0] on_th, hi_th;
  logic [15:0] lvl [3];
  logic [17:0] flg;
  int          num_errors = 0;
  int          comparisons = 0;
  integer      seed = 32'hF8C1;
  localparam logic [15:0] TBL [17] = '{16'h0700, 16'h0601, 16'h0302, 16'h0103,
    16'h0004, 16'h0410, 16'h1607, 16'h1508, 16'h1409, 16'h1211, 16'h110A, 16'h250B,
    16'h240C, 16'h230D, 16'h220E, 16'h210F, 16'h1005};
  localparam logic [15:0] MC [3] = '{CMD_VIN_READ, CMD_IIN_READ, CMD_VOUT_READ};
  localparam int EMN [3] = '{-3, -10, -3};
  localparam int EMX [3] = '{-1, -5, 0};

  ipmf_metering_flags dut_u (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .sample_strobe(sample_strobe),
    .line_voltage_input(v_smp), .line_current_sample(i_smp), .half_cycle_end(half_cycle_end),
    .vin_on_threshold(on_th), .high_line_threshold(hi_th), .vin_level(lvl[0]),
    .iin_level(lvl[1]), .vout_level(lvl[2]), .feedback_sense_pin(fb),
    .overvoltage_sense_pin(ov), .overvoltage_comparator(flg[16]),
    .current_limit_pin(flg[17]), .max_modulation(flg[0]), .min_modulation(flg[1]),
    .period_detect_fail(flg[2]), .soft_start_active(flg[3]), .relay_off(flg[4]),
    .vin_low(flg[5]), .output_bad(flg[6]), .nvm_unlocked(flg[7]), .nvm_crc_bad(flg[8]),
    .address_strap_marginal(flg[9]), .sync_locked(flg[10]), .light_load(flg[11]),
    .fast_loop_active(flg[12]), .core_rail_over(flg[13]), .supply_over(flg[14]),
    .supply_under(flg[15]), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .output_good_pin(og), .line_good_pin(lg), .relay_close_pin(rc),
    .supply_shutdown(sd), .mfr_status_bit(mfr));

  ipmf_host_model host_u (.clock(clock), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  function automatic logic [15:0] lin(input logic [15:0] x, input int emin, input int emax);
    logic [15:0] r;
    r = {5'(emax), 11'h3FF};
    for (int e = emax; e >= emin; e--) begin
      if ((x >> (e - emin)) < 16'h0400) r = {5'(e), 11'(x >> (e - emin))};
    end
    return r;
  endfunction

  function automatic logic [15:0] hc(input logic [11:0] v, input logic [11:0] i);
    logic [23:0] p;
    p = (24'(v) * 24'(i)) >> 13;
    return (p > 24'h0007FF) ? 16'h07FF : p[15:0];
  endfunction

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic rd(input logic [15:0] code, output logic [16:0] r);
    host_u.access(1'b0, code, 16'h0000, r);
  endtask

  // One sample then the half-cycle end, spaced so the end never drops the sample.
  task automatic half(input logic [11:0] v, input logic [11:0] i);
    @(posedge clock);
    sample_strobe <= 1'b1;
    v_smp <= v;
    i_smp <= i;
    @(posedge clock);
    sample_strobe <= 1'b0;
    @(posedge clock);
    half_cycle_end <= 1'b1;
    @(posedge clock);
    half_cycle_end <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    tick(20000);
    num_errors++;
    finish_test();
  end

  initial begin
    logic [16:0] r, p0;
    logic [15:0] h0, h1, d, t;
    logic [11:0] a, b;
    rst_n = 1'b0;
    sample_strobe = 1'b0;
    half_cycle_end = 1'b0;
    v_smp = 12'h000;
    i_smp = 12'h000;
    fb = 12'h000;
    ov = 12'h000;
    on_th = 11'h000;
    hi_th = 11'h7FF;
    lvl = '{16'h0000, 16'h0000, 16'h0000};
    flg = 18'h00000;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    rd(CMD_AVG_WINDOW, r);
    check("window reset", r, 17'h00001);
    host_u.access(1'b1, CMD_AVG_WINDOW, 16'h000D, r);
    rd(CMD_AVG_WINDOW, r);
    check("window", r, 17'h0000D);
    rd(16'h0000, r);
    check("unmapped", r, 17'h10000);
    host_u.access(1'b1, CMD_PIN_READ, 16'h1234, r);
    check("read-only write", r, 17'h10000);
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 3; j++) begin
        lvl[j] <= (k == 0) ? 16'h03FF : (k == 1) ? 16'hFFFF : 16'($random(seed));
      end
      tick(4);
      for (int j = 0; j < 3; j++) begin
        rd(MC[j], r);
        check("reading", r, {1'b0, lin(lvl[j], EMN[j], EMX[j])});
      end
    end
    host_u.access(1'b1, CMD_AVG_WINDOW, 16'h0000, r);
    a = 12'($random(seed));
    b = 12'($random(seed));
    half(a, b);
    tick(4);
    rd(CMD_PIN_READ, p0);
    check("power", p0, {1'b0, lin(hc(a, b), -4, 3)});
    host_u.access(1'b1, CMD_AVG_WINDOW, 16'h0001, r);
    a = 12'($random(seed));
    half(a, 12'hFFF);
    h0 = hc(a, 12'hFFF);
    tick(4);
    rd(CMD_PIN_READ, r);
    check("power held", r, p0);
    b = 12'($random(seed));
    half(b, b);
    h1 = hc(b, b);
    tick(4);
    rd(CMD_PIN_READ, r);
    check("power mean", r, {1'b0, lin((h0 + h1) >> 1, -4, 3)});
    host_u.access(1'b1, CMD_LINE_SRC, 16'h0004, r);
    rd(CMD_LINE_SRC, r);
    check("line source", r, 17'h00004);
    flg[5] <= 1'b1;
    flg[6] <= 1'b1;
    flg[4] <= 1'b1;
    flg[15] <= 1'b1;
    tick(4);
    check("pins bad", {13'h0000, lg, og, rc, sd}, 17'h00001);
    flg <= 18'h00000;
    tick(4);
    check("pins good", {13'h0000, lg, og, rc, sd}, 17'h0000E);
    for (int k = 0; k < 17; k++) begin
      t = TBL[k];
      flg[t[4:0]] <= 1'b1;
      tick(1);
      flg[t[4:0]] <= 1'b0;
      tick(6);
      check("status bit", {16'h0000, mfr}, 17'h00001);
      rd(16'hFE80 + {12'h000, t[15:12]}, r);
      check("latched", {16'h0000, r[t[11:8]]}, 17'h00001);
      rd(16'hFE80 + {12'h000, t[15:12]}, r);
      check("cleared", {16'h0000, r[t[11:8]]}, 17'h00000);
    end
    // The flag pulse lands on the very edge that takes the clearing read.
    fork
      rd(CMD_LAT_CTRL, r);
      begin
        tick(1);
        flg[0] <= 1'b1;
        tick(1);
        flg[0] <= 1'b0;
      end
    join
    tick(4);
    rd(CMD_LAT_CTRL, r);
    check("set beats clear", {16'h0000, r[7]}, 17'h00001);
    for (int k = 0; k < 10; k++) begin
      d = (k == 0) ? 16'h00FA : (k == 1) ? 16'h00FB : 16'($random(seed)) & 16'h01FF;
      a = 12'($random(seed)) & 12'h7FF;
      fb <= k[0] ? a + d[11:0] : a;
      ov <= k[0] ? a : a + d[11:0];
      tick(5);
      rd(CMD_LAT_CTRL, r);
      check("open loop", {16'h0000, r[5]}, {16'h0000, d > 16'h00FA});
      fb <= a;
      ov <= a;
      tick(4);
      rd(CMD_LAT_CTRL, r);
    end
    rd(CMD_LAT_SYS, r);
    rd(CMD_LAT_SUP, r);
    tick(2);
    check("status clear", {16'h0000, mfr}, 17'h00000);
    finish_test();
  end
endmodule
